// ---- tci_partner.sv ----
/*
 * Model of the pipeline, context manager and memory bus facing the trap unit: presents one
 * numbered cause for one cycle when asked, with fixed instruction addresses per cause.
 * Assumes go and code change by non-blocking assignment at a rising edge of clk_sys.
 */
`timescale 1ns/1ps
module tci_partner (
	input wire logic clk_sys, // Core clock.
	input wire logic reset, // Asynchronous reset, active high.
	input wire logic go, // Present the cause in the next cycle.
	input wire logic [4:0] code, // Cause to present.
	input wire logic [7:0] kimm, // Kernel call immediate.
	output tci_pkg::tci_sync_s sync_in, // Instruction causes.
	output tci_pkg::tci_ctx_s ctx_in, // Context events.
	output logic async_bus_err, // Unattributable bus error.
	output logic nmi_req, // Non-maskable interrupt.
	output logic [31:0] pc_current, // Committing instruction.
	output logic [31:0] pc_next, // Following instruction.
	output logic [31:0] handler_first_pc // First handler instruction.
);
	logic act;
	logic [4:0] cur;

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			act <= 1'b0;
			cur <= 5'h00;
		end else begin
			act <= go;
			cur <= code;
		end
	end

	// Addresses differ per cause so a return address taken from the wrong source shows up.
	assign pc_current = 32'h00002000 + {23'h0, cur, 4'h0};
	assign pc_next = pc_current + 32'h00000004;
	assign handler_first_pc = 32'h00003000 + {23'h0, cur, 4'h0};

	always_comb begin
		sync_in = '0;
		ctx_in = '0;
		async_bus_err = 1'b0;
		nmi_req = 1'b0;
		if (act) begin
			case (cur)
				5'd0: sync_in.illegal_opcode = 1'b1;
				5'd1: sync_in.unimplemented_opcode = 1'b1;
				5'd2: sync_in = '{pair_insn: 1'b1, odd_specifier: 1'b1, default: '0};
				5'd3: sync_in.misaligned = 1'b1;
				5'd4: sync_in.bad_addr_flagged = 1'b1;
				5'd5: sync_in = '{bad_addr_flagged: 1'b1, protection_fault: 1'b1, default: '0};
				5'd6: sync_in.fetch_err = 1'b1;
				5'd7: sync_in = '{fetch_err: 1'b1, fetch_prot: 1'b1, default: '0};
				5'd8: sync_in.data_err = 1'b1;
				5'd9: sync_in = '{data_err: 1'b1, data_prot: 1'b1, default: '0};
				5'd10: sync_in.ovf_insn = 1'b1;
				5'd11: sync_in.sticky_overflow_assert_trap_insn = 1'b1;
				5'd12: sync_in = '{kcall_insn: 1'b1, kcall_imm: kimm, default: '0};
				5'd13: ctx_in = '{save_done: 1'b1, save_at_limit: 1'b1, default: '0};
				5'd14: ctx_in = '{save_done: 1'b1, save_at_limit: 1'b1, save_from_entry: 1'b1, default: '0};
				5'd15: ctx_in = '{call_insn: 1'b1, depth_enable: 1'b1, depth_at_max: 1'b1, default: '0};
				5'd16: ctx_in = '{ret_insn: 1'b1, depth_enable: 1'b1, depth_zero: 1'b1, default: '0};
				5'd17: ctx_in = '{save_attempt: 1'b1, head_null: 1'b1, default: '0};
				5'd18: ctx_in = '{save_attempt: 1'b1, save_error: 1'b1, default: '0};
				5'd19: ctx_in = '{ret_insn: 1'b1, prev_invalid: 1'b1, default: '0};
				5'd20: ctx_in = '{rfe_insn: 1'b1, prev_invalid: 1'b1, depth_zero: 1'b1, default: '0};
				5'd21: ctx_in = '{restore_lower: 1'b1, ul_flag: 1'b1, depth_zero: 1'b1, default: '0};
				5'd22: ctx_in = '{restore_upper: 1'b1, depth_zero: 1'b1, default: '0};
				5'd23: ctx_in = '{rfe_insn: 1'b1, depth_enable: 1'b1, default: '0};
				5'd24: async_bus_err = 1'b1;
				5'd25: nmi_req = 1'b1;
				default: nmi_req = 1'b0;
			endcase
		end
	end
endmodule : tci_partner

// ---- tci_pkg.sv ----
/*
 * Package for the trap cause identifier: trap classes, trap numbers, register layouts and the
 * packed structs that carry exception causes, context state and the trap entry result.
 * Assumes a 32-bit core with a single clock and an APB register bus.
 */
package tci_pkg;
	localparam logic [2:0] CLS_INSN = 3'h2;
	localparam logic [2:0] CLS_CTX = 3'h3;
	localparam logic [2:0] CLS_BUS = 3'h4;
	localparam logic [2:0] CLS_ASSERT = 3'h5;
	localparam logic [2:0] CLS_KCALL = 3'h6;
	localparam logic [2:0] CLS_NMI = 3'h7;
	localparam int CLASS_SHIFT = 5;
	localparam logic [7:0] TIN_ILLEGAL = 8'h01;
	localparam logic [7:0] TIN_UNIMPL = 8'h02;
	localparam logic [7:0] TIN_ODD_PAIR = 8'h03;
	localparam logic [7:0] TIN_ALIGN = 8'h04;
	localparam logic [7:0] TIN_BAD_ADDR = 8'h05;
	localparam logic [7:0] TIN_DEPLETION = 8'h01;
	localparam logic [7:0] TIN_DEPTH_OVF = 8'h02;
	localparam logic [7:0] TIN_DEPTH_UNF = 8'h03;
	localparam logic [7:0] TIN_FREE_UNF = 8'h04;
	localparam logic [7:0] TIN_STACK_UNF = 8'h05;
	localparam logic [7:0] TIN_CTX_TYPE = 8'h06;
	localparam logic [7:0] TIN_HANDLER_RETURN_DEPTH_TRAP = 8'h07;
	localparam logic [7:0] TIN_FETCH_ERR = 8'h01;
	localparam logic [7:0] TIN_DATA_SERR = 8'h02;
	localparam logic [7:0] TIN_DATA_AERR = 8'h03;
	localparam logic [7:0] TIN_OVF = 8'h01;
	localparam logic [7:0] TIN_STICKY_OVERFLOW_ASSERT_TRAP = 8'h02;
	localparam logic [7:0] TIN_NMI = 8'h00;
	localparam logic [6:0] DEPTH_LIMIT_64 = 7'h40;
	localparam logic [11:0] ADDR_CTRL = 12'h000;
	localparam logic [11:0] ADDR_VBASE = 12'h004;
	localparam logic [11:0] ADDR_STATUS = 12'h008;
	localparam logic [11:0] ADDR_DATA = 12'h00C;
	localparam logic [11:0] ADDR_RET = 12'h010;
	localparam logic [11:0] ADDR_CFG = 12'h014;
	localparam int CTRL_ODD_TRAP = 0;
	localparam int CFG_DEPLETION = 0;
	localparam logic [31:0] VBASE_RESET = 32'h00000000;

	typedef struct packed {
		logic illegal_opcode;
		logic unimplemented_opcode;
		logic pair_insn;
		logic odd_specifier;
		logic misaligned;
		logic protection_fault;
		logic bad_addr_flagged;
		logic fetch_err;
		logic fetch_prot;
		logic data_err;
		logic data_prot;
		logic ovf_insn;
		logic sticky_overflow_assert_trap_insn;
		logic kcall_insn;
		logic [7:0] kcall_imm;
	} tci_sync_s;

	typedef struct packed {
		logic save_done;
		logic save_at_limit;
		logic save_from_entry;
		logic save_attempt;
		logic head_null;
		logic save_error;
		logic call_insn;
		logic ret_insn;
		logic rfe_insn;
		logic prev_invalid;
		logic restore_lower;
		logic restore_upper;
		logic ul_flag;
		logic depth_enable;
		logic depth_at_max;
		logic depth_zero;
	} tci_ctx_s;

	typedef struct packed {
		logic valid;
		logic [2:0] trap_class;
		logic [7:0] trap_id_number;
		logic [31:0] handler_addr;
		logic [31:0] return_addr;
		logic sync_trap;
	} tci_trap_s;
endpackage : tci_pkg

// ---- tci_trap_unit.sv ----
/*
 * Trap cause identifier: picks the highest priority pending exception, forms its trap class and
 * trap number, the return address and the handler entry, and drives the trap entry state.
 * Assumes the pipeline presents causes for the instruction at pc_current in the cycle it
 * would commit, and holds the pipeline while trap_out.valid is high.
 */
// Local design decisions: the APB slave port and the address map.
`timescale 1ns/1ps
module tci_trap_unit (
	input wire logic clk_sys, // Core clock, 200 MHz.
	input wire logic reset, // Asynchronous reset, active high.
	input wire logic psel, // APB select.
	input wire logic penable, // APB access phase.
	input wire logic pwrite, // APB direction.
	input wire logic [11:0] paddr, // APB byte address.
	input wire logic [31:0] pwdata, // APB write data.
	output logic [31:0] prdata, // APB read data.
	output logic pready, // APB ready.
	output logic pslverr, // APB error for unmapped address.
	input wire tci_pkg::tci_sync_s sync_in, // Synchronous causes of current instruction.
	input wire tci_pkg::tci_ctx_s ctx_in, // Context manager events.
	input wire logic async_bus_err, // Unattributable memory error pulse.
	input wire logic nmi_req, // Non-maskable interrupt pulse.
	input wire logic [31:0] pc_current, // Address of instruction being committed.
	input wire logic [31:0] pc_next, // Address of the following instruction.
	input wire logic [31:0] handler_first_pc, // First instruction of handler just entered.
	input wire logic [7:0] current_priority_number, // Interrupt priority, passed through.
	output tci_pkg::tci_trap_s trap_out, // Trap entry result, one cycle.
	output logic [31:0] implicit_data_reg, // Trap number for the data register.
	output logic irq_disable, // Disable interrupts on entry.
	output logic perm_enable_all, // Enable all permissions on entry.
	output logic [1:0] protection_set, // Protection set on entry.
	output logic use_interrupt_stack, // Select interrupt stack on entry.
	output logic depth_clear, // Clear call depth counter on entry.
	output logic [6:0] depth_limit, // Call depth limit on entry.
	output logic [7:0] priority_out, // Priority after entry.
	output logic save_abandon // Abandon the failing context save.
);
	logic [31:0] vbase;
	logic odd_trap_en;
	logic depletion_flag;
	logic async_pend;
	logic nmi_pend;
	logic dep_pend;
	logic [31:0] dep_ret;
	logic [7:0] sticky;
	logic [31:0] last_ret;
	tci_pkg::tci_trap_s next_trap;
	logic take_async;
	logic take_nmi;
	logic take_dep;

	function automatic logic [31:0] vector_of(input logic [31:0] base, input logic [2:0] cls);
		vector_of = base | (32'(cls) << tci_pkg::CLASS_SHIFT);
	endfunction : vector_of

	// Instruction and bus causes first, then context faults, then assertions, kernel call and pending events; returns valid, class, number.
	always_comb begin
		next_trap = '0;
		take_async = 1'b0;
		take_nmi = 1'b0;
		take_dep = 1'b0;
		next_trap.sync_trap = 1'b1;
		next_trap.return_addr = pc_current;
		if (sync_in.illegal_opcode) begin
			next_trap.valid = 1'b1;
			next_trap.trap_class = tci_pkg::CLS_INSN;
			next_trap.trap_id_number = tci_pkg::TIN_ILLEGAL;
		end else if (sync_in.unimplemented_opcode) begin
			next_trap.valid = 1'b1;
			next_trap.trap_class = tci_pkg::CLS_INSN;
			next_trap.trap_id_number = tci_pkg::TIN_UNIMPL;
		end else if (odd_trap_en && sync_in.pair_insn && sync_in.odd_specifier) begin
			next_trap.valid = 1'b1;
			next_trap.trap_class = tci_pkg::CLS_INSN;
			next_trap.trap_id_number = tci_pkg::TIN_ODD_PAIR;
		end else if (sync_in.fetch_err && !sync_in.fetch_prot) begin
			next_trap.valid = 1'b1;
			next_trap.trap_class = tci_pkg::CLS_BUS;
			next_trap.trap_id_number = tci_pkg::TIN_FETCH_ERR;
		end else if (sync_in.misaligned) begin
			next_trap.valid = 1'b1;
			next_trap.trap_class = tci_pkg::CLS_INSN;
			next_trap.trap_id_number = tci_pkg::TIN_ALIGN;
		end else if (sync_in.bad_addr_flagged && !sync_in.protection_fault) begin
			// Only raised when flagged in time; misses come back as the asynchronous error.
			next_trap.valid = 1'b1;
			next_trap.trap_class = tci_pkg::CLS_INSN;
			next_trap.trap_id_number = tci_pkg::TIN_BAD_ADDR;
		end else if (sync_in.data_err && !sync_in.data_prot) begin
			next_trap.valid = 1'b1;
			next_trap.trap_class = tci_pkg::CLS_BUS;
			next_trap.trap_id_number = tci_pkg::TIN_DATA_SERR;
		end else if (ctx_in.save_attempt && (ctx_in.head_null || ctx_in.save_error)) begin
			next_trap.valid = 1'b1;
			next_trap.trap_class = tci_pkg::CLS_CTX;
			next_trap.trap_id_number = tci_pkg::TIN_FREE_UNF;
		end else if (ctx_in.call_insn && ctx_in.depth_enable && ctx_in.depth_at_max) begin
			next_trap.valid = 1'b1;
			next_trap.trap_class = tci_pkg::CLS_CTX;
			next_trap.trap_id_number = tci_pkg::TIN_DEPTH_OVF;
		end else if ((ctx_in.ret_insn || ctx_in.rfe_insn) && ctx_in.prev_invalid) begin
			next_trap.valid = 1'b1;
			next_trap.trap_class = tci_pkg::CLS_CTX;
			next_trap.trap_id_number = tci_pkg::TIN_STACK_UNF;
		end else if (ctx_in.ret_insn && ctx_in.depth_enable && ctx_in.depth_zero) begin
			next_trap.valid = 1'b1;
			next_trap.trap_class = tci_pkg::CLS_CTX;
			next_trap.trap_id_number = tci_pkg::TIN_DEPTH_UNF;
		end else if (ctx_in.rfe_insn && !ctx_in.depth_zero) begin
			next_trap.valid = 1'b1;
			next_trap.trap_class = tci_pkg::CLS_CTX;
			next_trap.trap_id_number = tci_pkg::TIN_HANDLER_RETURN_DEPTH_TRAP;
		end else if ((ctx_in.restore_lower && ctx_in.ul_flag) || (ctx_in.restore_upper && !ctx_in.ul_flag)) begin
			next_trap.valid = 1'b1;
			next_trap.trap_class = tci_pkg::CLS_CTX;
			next_trap.trap_id_number = tci_pkg::TIN_CTX_TYPE;
		end else if (sync_in.ovf_insn) begin
			next_trap.valid = 1'b1;
			next_trap.trap_class = tci_pkg::CLS_ASSERT;
			next_trap.trap_id_number = tci_pkg::TIN_OVF;
		end else if (sync_in.sticky_overflow_assert_trap_insn) begin
			next_trap.valid = 1'b1;
			next_trap.trap_class = tci_pkg::CLS_ASSERT;
			next_trap.trap_id_number = tci_pkg::TIN_STICKY_OVERFLOW_ASSERT_TRAP;
		end else if (sync_in.kcall_insn) begin
			next_trap.valid = 1'b1;
			next_trap.trap_class = tci_pkg::CLS_KCALL;
			next_trap.trap_id_number = sync_in.kcall_imm;
			next_trap.return_addr = pc_next;
			next_trap.sync_trap = 1'b0;
		end else if (dep_pend) begin
			next_trap.valid = 1'b1;
			take_dep = 1'b1;
			next_trap.trap_class = tci_pkg::CLS_CTX;
			next_trap.trap_id_number = tci_pkg::TIN_DEPLETION;
			next_trap.return_addr = dep_ret;
			next_trap.sync_trap = 1'b0;
		end else if (nmi_pend) begin
			next_trap.valid = 1'b1;
			take_nmi = 1'b1;
			next_trap.trap_class = tci_pkg::CLS_NMI;
			next_trap.trap_id_number = tci_pkg::TIN_NMI;
			next_trap.return_addr = pc_next;
			next_trap.sync_trap = 1'b0;
		end else if (async_pend) begin
			next_trap.valid = 1'b1;
			take_async = 1'b1;
			next_trap.trap_class = tci_pkg::CLS_BUS;
			next_trap.trap_id_number = tci_pkg::TIN_DATA_AERR;
			next_trap.return_addr = pc_next;
			next_trap.sync_trap = 1'b0;
		end
		next_trap.handler_addr = vector_of(vbase, next_trap.trap_class);
	end

	// Pending asynchronous events; a new event wins over the take in the same cycle.
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			async_pend <= 1'b0;
			nmi_pend <= 1'b0;
		end else begin
			async_pend <= async_bus_err || (async_pend && !take_async);
			nmi_pend <= nmi_req || (nmi_pend && !take_nmi);
		end
	end

	// Depletion trap follows the completed save; entry saves return to the handler's first pc.
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			dep_pend <= 1'b0;
			dep_ret <= 32'h00000000;
		end else if (ctx_in.save_done && ctx_in.save_at_limit) begin
			dep_pend <= 1'b1;
			dep_ret <= ctx_in.save_from_entry ? handler_first_pc : pc_next;
		end else if (take_dep) begin
			dep_pend <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			trap_out <= '0;
			implicit_data_reg <= 32'h00000000;
			save_abandon <= 1'b0;
		end else begin
			trap_out <= next_trap;
			save_abandon <= next_trap.valid && next_trap.trap_class == tci_pkg::CLS_CTX
				&& next_trap.trap_id_number == tci_pkg::TIN_FREE_UNF;
			if (next_trap.valid) begin
				implicit_data_reg <= {24'h000000, next_trap.trap_id_number};
			end
		end
	end

	// Entry state is a level for the one entry cycle.
	always_comb begin
		irq_disable = trap_out.valid;
		perm_enable_all = trap_out.valid;
		protection_set = 2'h0;
		use_interrupt_stack = trap_out.valid;
		depth_clear = trap_out.valid;
		depth_limit = tci_pkg::DEPTH_LIMIT_64;
		priority_out = current_priority_number;
	end

	// Registers: software writes steer the vector base and the odd pair option.
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			vbase <= tci_pkg::VBASE_RESET;
			odd_trap_en <= 1'b0;
		end else if (psel && penable && pwrite) begin
			if (paddr == tci_pkg::ADDR_CTRL) begin
				odd_trap_en <= pwdata[tci_pkg::CTRL_ODD_TRAP];
			end
			if (paddr == tci_pkg::ADDR_VBASE) begin
				vbase <= {pwdata[31:8], 8'h00};
			end
		end
	end

	// Depletion flag: hardware set wins over a software clear in the same cycle.
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			depletion_flag <= 1'b0;
		end else if (take_dep) begin
			depletion_flag <= 1'b1;
		end else if (psel && penable && pwrite && paddr == tci_pkg::ADDR_CFG) begin
			depletion_flag <= pwdata[tci_pkg::CFG_DEPLETION];
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			sticky <= 8'h00;
		end else if (next_trap.valid) begin
			sticky <= {5'h00, next_trap.trap_class};
		end
	end

	// Software reads the return address long after the one-cycle trap_out pulse has gone.
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			last_ret <= 32'h00000000;
		end else if (next_trap.valid) begin
			last_ret <= next_trap.return_addr;
		end
	end

	function automatic logic mapped(input logic [11:0] a);
		mapped = a == tci_pkg::ADDR_CTRL || a == tci_pkg::ADDR_VBASE || a == tci_pkg::ADDR_STATUS
			|| a == tci_pkg::ADDR_DATA || a == tci_pkg::ADDR_RET || a == tci_pkg::ADDR_CFG;
	endfunction : mapped

	always_comb begin
		pready = 1'b1;
		pslverr = psel && penable && !mapped(paddr);
		case (paddr)
			tci_pkg::ADDR_CTRL: prdata = {31'h00000000, odd_trap_en};
			tci_pkg::ADDR_VBASE: prdata = vbase;
			tci_pkg::ADDR_STATUS: prdata = {24'h000000, sticky};
			tci_pkg::ADDR_DATA: prdata = implicit_data_reg;
			tci_pkg::ADDR_RET: prdata = last_ret;
			tci_pkg::ADDR_CFG: prdata = {31'h00000000, depletion_flag};
			default: prdata = 32'h00000000;
		endcase
	end

	chk_illegal_class: assert property (@(posedge clk_sys) disable iff (reset)
		sync_in.illegal_opcode |=> trap_out.valid && trap_out.trap_class == 3'h2 && trap_out.trap_id_number == 8'h01)
		else $error("illegal opcode trap wrong");
	chk_unimpl_number: assert property (@(posedge clk_sys) disable iff (reset)
		!sync_in.illegal_opcode && sync_in.unimplemented_opcode |=> trap_out.trap_id_number == 8'h02)
		else $error("unimplemented opcode trap wrong");
	chk_vector_addr: assert property (@(posedge clk_sys) disable iff (reset)
		trap_out.valid |-> trap_out.handler_addr == (vbase | {24'h0, trap_out.trap_class, 5'h00}))
		else $error("handler address wrong");
	chk_data_reg: assert property (@(posedge clk_sys) disable iff (reset)
		trap_out.valid |-> implicit_data_reg[7:0] == trap_out.trap_id_number)
		else $error("data register not loaded");
	chk_depletion_flag: assert property (@(posedge clk_sys) disable iff (reset)
		take_dep |=> depletion_flag)
		else $error("depletion flag not set");
	chk_depletion_after: assert property (@(posedge clk_sys) disable iff (reset)
		ctx_in.save_done && ctx_in.save_at_limit |=> dep_pend)
		else $error("depletion not pending");
	chk_kcall_return: assert property (@(posedge clk_sys) disable iff (reset)
		next_trap.valid && next_trap.trap_class == 3'h6 |=> trap_out.return_addr == $past(pc_next))
		else $error("kernel call return wrong");
	chk_priority_kept: assert property (@(posedge clk_sys) disable iff (reset)
		trap_out.valid |-> priority_out == current_priority_number && depth_limit == 7'h40)
		else $error("entry state wrong");
	chk_nmi_taken: assert property (@(posedge clk_sys) disable iff (reset)
		take_nmi |=> trap_out.valid && trap_out.trap_class == 3'h7 && trap_out.trap_id_number == 8'h00)
		else $error("nmi number wrong");
	chk_nmi_pending: assert property (@(posedge clk_sys) disable iff (reset)
		nmi_req |=> nmi_pend)
		else $error("nmi not pending");
	chk_async_pending: assert property (@(posedge clk_sys) disable iff (reset)
		async_bus_err |=> async_pend)
		else $error("bus error not pending");
	chk_async_return: assert property (@(posedge clk_sys) disable iff (reset)
		take_async |=> trap_out.return_addr == $past(pc_next) && !trap_out.sync_trap
			&& trap_out.trap_id_number == 8'h03)
		else $error("asynchronous return wrong");
	chk_sync_return: assert property (@(posedge clk_sys) disable iff (reset)
		next_trap.valid && next_trap.sync_trap |=> trap_out.return_addr == $past(pc_current))
		else $error("synchronous return wrong");
	chk_ret_register: assert property (@(posedge clk_sys) disable iff (reset)
		trap_out.valid |-> last_ret == trap_out.return_addr)
		else $error("return register stale");
	chk_odd_number: assert property (@(posedge clk_sys) disable iff (reset)
		odd_trap_en && sync_in.pair_insn && sync_in.odd_specifier && !sync_in.illegal_opcode
			&& !sync_in.unimplemented_opcode |=> trap_out.trap_class == 3'h2 && trap_out.trap_id_number == 8'h03)
		else $error("odd pair trap wrong");
	chk_odd_ignored: assert property (@(posedge clk_sys) disable iff (reset)
		!odd_trap_en |=> !(trap_out.valid && trap_out.trap_class == 3'h2 && trap_out.trap_id_number == 8'h03))
		else $error("odd pair trap while ignored");
	chk_align_number: assert property (@(posedge clk_sys) disable iff (reset)
		sync_in.misaligned && !sync_in.illegal_opcode && !sync_in.unimplemented_opcode && !sync_in.pair_insn
			&& !sync_in.fetch_err |=> trap_out.trap_class == 3'h2 && trap_out.trap_id_number == 8'h04)
		else $error("alignment trap wrong");
	chk_protection_wins: assert property (@(posedge clk_sys) disable iff (reset)
		sync_in.protection_fault |=> !(trap_out.valid && trap_out.trap_class == 3'h2 && trap_out.trap_id_number == 8'h05))
		else $error("bad address trap despite protection fault");
	chk_abandon_save: assert property (@(posedge clk_sys) disable iff (reset)
		sync_in == '0 && ctx_in.save_attempt && ctx_in.head_null |=> save_abandon && trap_out.trap_id_number == 8'h04)
		else $error("failed save not abandoned");
	chk_handler_return_depth_trap_number: assert property (@(posedge clk_sys) disable iff (reset)
		sync_in == '0 && ctx_in.rfe_insn && !ctx_in.depth_zero && !ctx_in.prev_invalid && !ctx_in.save_attempt
			&& !ctx_in.call_insn |=> trap_out.trap_class == 3'h3 && trap_out.trap_id_number == 8'h07)
		else $error("nesting trap wrong");
	chk_entry_levels: assert property (@(posedge clk_sys) disable iff (reset)
		trap_out.valid |-> irq_disable && perm_enable_all && use_interrupt_stack && depth_clear && protection_set == 2'h0)
		else $error("entry levels wrong");
	chk_dep_return: assert property (@(posedge clk_sys) disable iff (reset)
		ctx_in.save_done && ctx_in.save_at_limit && ctx_in.save_from_entry |=> dep_ret == $past(handler_first_pc))
		else $error("depletion return wrong");
	cov_async: cover property (@(posedge clk_sys) disable iff (reset) take_async);
	cov_nmi: cover property (@(posedge clk_sys) disable iff (reset) trap_out.valid && trap_out.trap_class == 3'h7);
	cov_depletion: cover property (@(posedge clk_sys) disable iff (reset) take_dep);
	cov_kcall: cover property (@(posedge clk_sys) disable iff (reset) trap_out.valid && trap_out.trap_class == 3'h6);
endmodule : tci_trap_unit

// ---- test_trap_cause_identifier.sv ----
/*
 * Self-checking bench for the trap cause identifier: APB register access and one pass through
 * every trap cause, comparing class, number, vector, return address and entry state.
 * Assumes tci_pkg, tci_trap_unit and tci_partner are compiled before it.
 */
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_mismatch++; $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
module test_trap_cause_identifier;
	localparam logic [31:0] VB = 32'h80001000;
	logic clk_sys = 1'b0;
	logic reset = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	tci_pkg::tci_sync_s sync_in;
	tci_pkg::tci_ctx_s ctx_in;
	logic async_bus_err;
	logic nmi_req;
	logic [31:0] pc_current;
	logic [31:0] pc_next;
	logic [31:0] handler_first_pc;
	logic [7:0] cpn = 8'h5A;
	tci_pkg::tci_trap_s trap_out;
	logic [31:0] implicit_data_reg;
	logic irq_disable;
	logic perm_enable_all;
	logic [1:0] protection_set;
	logic use_interrupt_stack;
	logic depth_clear;
	logic [6:0] depth_limit;
	logic [7:0] priority_out;
	logic save_abandon;
	logic go = 1'b0;
	logic [4:0] code = 5'h00;
	logic [7:0] kimm = 8'hA7;
	logic odd_on = 1'b0;
	logic [31:0] rd;
	logic er;
	int n_mismatch = 0;
	int n_tests = 0;

	tci_trap_unit i_tci_trap_unit (.clk_sys(clk_sys), .reset(reset), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.sync_in(sync_in), .ctx_in(ctx_in), .async_bus_err(async_bus_err), .nmi_req(nmi_req),
		.pc_current(pc_current), .pc_next(pc_next), .handler_first_pc(handler_first_pc),
		.current_priority_number(cpn), .trap_out(trap_out), .implicit_data_reg(implicit_data_reg),
		.irq_disable(irq_disable), .perm_enable_all(perm_enable_all), .protection_set(protection_set),
		.use_interrupt_stack(use_interrupt_stack), .depth_clear(depth_clear), .depth_limit(depth_limit),
		.priority_out(priority_out), .save_abandon(save_abandon));

	tci_partner i_tci_partner (.clk_sys(clk_sys), .reset(reset), .go(go), .code(code), .kimm(kimm),
		.sync_in(sync_in), .ctx_in(ctx_in), .async_bus_err(async_bus_err), .nmi_req(nmi_req),
		.pc_current(pc_current), .pc_next(pc_next), .handler_first_pc(handler_first_pc));

	initial begin
		forever #2.5 clk_sys = ~clk_sys;
	end

	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : complete_run

	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int i;
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		for (i = 0; i < 16; i++) begin
			@(posedge clk_sys);
			if (pready === 1'b1) break;
		end
		if (i == 16) begin
			n_mismatch++;
			complete_run();
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// Packed as {trap expected, class, number, return source: 0 current, 1 next, 2 handler}.
	function automatic logic [13:0] expect_of(input logic [4:0] c);
		case (c)
			5'd0: return {1'b1, 3'h2, 8'h01, 2'd0};
			5'd1: return {1'b1, 3'h2, 8'h02, 2'd0};
			5'd2: return {1'b1, 3'h2, 8'h03, 2'd0};
			5'd3: return {1'b1, 3'h2, 8'h04, 2'd0};
			5'd4: return {1'b1, 3'h2, 8'h05, 2'd0};
			5'd6: return {1'b1, 3'h4, 8'h01, 2'd0};
			5'd8: return {1'b1, 3'h4, 8'h02, 2'd0};
			5'd10: return {1'b1, 3'h5, 8'h01, 2'd0};
			5'd11: return {1'b1, 3'h5, 8'h02, 2'd0};
			5'd12: return {1'b1, 3'h6, 8'hA7, 2'd1};
			5'd13: return {1'b1, 3'h3, 8'h01, 2'd1};
			5'd14: return {1'b1, 3'h3, 8'h01, 2'd2};
			5'd15: return {1'b1, 3'h3, 8'h02, 2'd0};
			5'd16: return {1'b1, 3'h3, 8'h03, 2'd0};
			5'd17, 5'd18: return {1'b1, 3'h3, 8'h04, 2'd0};
			5'd19, 5'd20: return {1'b1, 3'h3, 8'h05, 2'd0};
			5'd21, 5'd22: return {1'b1, 3'h3, 8'h06, 2'd0};
			5'd23: return {1'b1, 3'h3, 8'h07, 2'd0};
			5'd24: return {1'b1, 3'h4, 8'h03, 2'd1};
			5'd25: return {1'b1, 3'h7, 8'h00, 2'd1};
			default: return 14'h0000;
		endcase
	endfunction : expect_of

	task automatic run_cause(input logic [4:0] c);
		logic [13:0] e;
		logic [31:0] ret;
		int i;
		e = expect_of(c);
		if (c == 5'd2 && !odd_on) e = 14'h0000;
		ret = (e[1:0] == 2'd2) ? 32'h00003000 + {23'h0, c, 4'h0} : 32'h00002000 + {23'h0, c, 1'b0, e[0], 2'h0};
		@(posedge clk_sys);
		code <= c;
		cpn <= 8'h5A ^ {3'h0, c};
		go <= 1'b1;
		@(posedge clk_sys);
		go <= 1'b0;
		for (i = 0; i < 6; i++) begin
			@(negedge clk_sys);
			if (trap_out.valid === 1'b1) break;
		end
		`CHK(i < 6, e[13])
		if (e[13] && i == 6) complete_run();
		if (e[13]) begin
			`CHK(trap_out.trap_class, e[12:10])
			`CHK(trap_out.trap_id_number, e[9:2])
			`CHK(implicit_data_reg, {24'h0, e[9:2]})
			`CHK(trap_out.handler_addr, VB | {24'h0, e[12:10], 5'h00})
			`CHK(trap_out.return_addr, ret)
			`CHK(trap_out.sync_trap, e[1:0] == 2'd0)
			`CHK({irq_disable, perm_enable_all, use_interrupt_stack, depth_clear}, 4'hF)
			`CHK({protection_set, depth_limit}, 9'h040)
			`CHK(priority_out, 8'h5A ^ {3'h0, c})
			`CHK(save_abandon, c == 5'd17 || c == 5'd18)
		end
		repeat (4) @(posedge clk_sys);
	endtask : run_cause

	initial begin
		int k;
		repeat (5) @(posedge clk_sys);
		reset <= 1'b0;
		for (k = 0; k < 6; k++) begin
			apb(1'b0, 12'(k * 4), 32'h00000000);
			`CHK({er, rd}, 33'h000000000)
		end
		apb(1'b1, 12'h018, 32'hFFFFFFFF);
		`CHK(er, 1'b1)
		apb(1'b0, 12'h018, 32'h00000000);
		`CHK({er, rd}, 33'h100000000)
		apb(1'b1, tci_pkg::ADDR_VBASE, VB);
		apb(1'b0, tci_pkg::ADDR_VBASE, 32'h00000000);
		`CHK(rd, VB)
		$display("test registers done");
		for (k = 0; k < 26; k++) run_cause(5'(k));
		$display("test causes done");
		apb(1'b0, tci_pkg::ADDR_CFG, 32'h00000000);
		`CHK(rd[0], 1'b1)
		apb(1'b1, tci_pkg::ADDR_CFG, 32'h00000000);
		apb(1'b0, tci_pkg::ADDR_CFG, 32'h00000000);
		`CHK(rd[0], 1'b0)
		run_cause(5'd13);
		apb(1'b0, tci_pkg::ADDR_CFG, 32'h00000000);
		`CHK(rd[0], 1'b1)
		apb(1'b1, tci_pkg::ADDR_CTRL, 32'h00000001);
		odd_on = 1'b1;
		run_cause(5'd2);
		apb(1'b0, tci_pkg::ADDR_STATUS, 32'h00000000);
		`CHK(rd, 32'h00000002)
		apb(1'b0, tci_pkg::ADDR_DATA, 32'h00000000);
		`CHK(rd, 32'h00000003)
		apb(1'b0, tci_pkg::ADDR_RET, 32'h00000000);
		`CHK(rd, 32'h00002020)
		$display("test config done");
		complete_run();
	end
endmodule : test_trap_cause_identifier
